//--- pkg/loa_consts.vh
// Constants of the byte-wide logical operate unit.
// Included by bare name; holds definitions only.
`ifndef LOA_CONSTS_VH
`define LOA_CONSTS_VH

// Data and field widths
`define LOA_DW          8
`define LOA_FILE_AW     4
`define LOA_FILE_CNT    16

// Command field bits, index into the 4-bit field c[7:4]
`define LOA_C_LINK      3
`define LOA_C_COMP      2
`define LOA_C_TRUE      1
`define LOA_C_FLAGS     0
// Copy command reuses bit 6 as add-one
`define LOA_C_ADD1      2

// Destination field: top bit inhibits file write, low three pick a register
`define LOA_R_INHIBIT   3
`define LOA_DST_NONE    3'h0
`define LOA_DST_T       3'h1
`define LOA_DST_M       3'h2
`define LOA_DST_N       3'h3
`define LOA_DST_U       3'h4

// Operate codes presented with each command
`define LOA_OP_COPY     3'h0
`define LOA_OP_OR       3'h1
`define LOA_OP_XOR      3'h2
`define LOA_OP_AND      3'h3
`define LOA_OP_INSET    3'h4
`define LOA_OP_INCLR    3'h5

// Reset values
`define LOA_RST_BYTE    8'h00
`define LOA_RST_BIT     1'b0
`define LOA_RST_NIB     4'h0

// Execution period
`define LOA_EXEC_NS     220
`define LOA_CLK_NS      20
`define LOA_EXEC_CYC    ((`LOA_EXEC_NS) / (`LOA_CLK_NS))

`endif

//--- hw/loa_operand_sel.v
// Operand selector of the logical operate unit.
// Assumes the caller picks in_flag and the command bits; purely combinational.
`timescale 1ns/10ps
`include "loa_consts.vh"

module loa_operand_sel (
	input  wire [7:0] t_val,     // Transfer register
	input  wire [7:0] in_bus,    // Input bus
	input  wire       in_flag,   // Input select flag
	input  wire       sel_true,  // Select true operand
	input  wire       sel_comp,  // Select complement operand
	output wire [7:0] operand    // Effective operand
);

	wire [7:0] src;

	// Input bus replaces the transfer register while the flag is set
	assign src = in_flag ? in_bus : t_val; // [RQ7]

	genvar gi;
	generate
		for (gi = 0; gi < `LOA_DW; gi = gi + 1) begin : g_bit
			// Complement of the source when the input flag is set is not expected
			assign operand[gi] = (sel_true & src[gi]) |
				(sel_comp & ~src[gi]); // [RQ6] [RQ7] [RQ9]
		end
	endgenerate

endmodule

//--- hw/loa_alu.v
// Byte-wide logical operate unit: OR, XOR, AND and copy commands.
// Assumes the sequencer presents one command at a time while ready is high.
//
// Overview of operation
// RQ1: OR operand into file, write file and destination
// RQ2: XOR operand into file, same routing
// RQ3: AND operand into file, same routing
// RQ4: Logical commands never change the carry bit
// RQ5: Bit 7 lets zero flag clear only
// RQ6: Bit 6 complements operand; with bit 5 ones
// RQ7: Bit 5 selects transfer or input; else zero
// RQ8: Bit 4 updates flags; otherwise flags hold
// RQ9: Sequencer never complements while input selected
// RQ10: XOR with both bits gives ones complement
// RQ11: AND with both bits passes file unchanged
// RQ12: Each logical command finishes within 220 ns
// RQ13: Code 1001 writes transfer register only
// RQ14: Code 0011 writes file and second register
// RQ15: Code 1000 inhibited stores nothing, flags only
// RQ16: Copy with no operand clears file, destination
// RQ17: Copy to file zero leaves it unchanged
// RQ18: After input set, copy takes input bus
// RQ19: Copy with add-one gives transfer plus one
// RQ20: Eight-bit data, four-bit command field
`timescale 1ns/10ps
`include "loa_consts.vh"

module loa_alu (
	input  wire       clk_sys,       // 50 MHz clock
	input  wire       arst_n,        // Asynchronous reset, active low
	input  wire       cmd_valid,     // Command presented
	input  wire [2:0] cmd_op,        // Operate code
	input  wire [3:0] cmd_file,      // File register address
	input  wire [3:0] cmd_c,         // Command field bits 7..4
	input  wire [3:0] cmd_r,         // Destination field, bit 3 inhibits file
	input  wire [7:0] in_bus,        // Input bus
	input  wire       t_load,        // Outside load of transfer register
	input  wire [7:0] t_load_data,   // Data for that load
	input  wire       link_load,     // Outside load of carry bit
	input  wire       link_load_val, // Value for that load
	input  wire       file_wr,       // Outside write of a file register
	input  wire [3:0] file_wr_addr,  // Address of that write
	input  wire [7:0] file_wr_data,  // Data of that write
	input  wire [3:0] file_rd_addr,  // File read address
	output reg        cmd_ready_q,   // Ready for a command
	output reg        cmd_done_q,    // Command finished, one cycle
	output reg  [7:0] result_q,      // Result of last command
	output reg  [7:0] t_q,           // Transfer register
	output reg  [7:0] m_q,           // Memory address register
	output reg  [7:0] n_q,           // Second address register
	output reg  [7:0] u_q,           // Command modifier register
	output reg        zero_q,        // Zero condition flag
	output reg        neg_q,         // Negative condition flag
	output reg        link_q,        // Carry bit
	output reg        in_flag_q,     // Input select flag
	output reg  [7:0] file_rd_q      // File read data
);

	// One-hot sequencer states
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_EXEC = 3'b010;
	localparam [2:0] ST_DONE = 3'b100;

	reg [2:0] state_q;
	reg [2:0] state_d;

	// Latched command
	reg [2:0] op_q;
	reg [3:0] file_q;
	reg [3:0] c_q;
	reg [3:0] r_q;

	// File registers
	reg [7:0] file_mem [0:`LOA_FILE_CNT-1]; // [RQ20]

	wire [7:0] file_val;
	wire [7:0] logic_opnd;
	wire [7:0] copy_src;
	wire       is_logic;
	wire       is_copy;
	wire       inhibit;
	wire [2:0] dst;

	reg  [7:0] res_d;
	reg        file_we_d;
	reg        flags_we_d;
	reg        zero_d;
	reg        neg_d;
	reg  [8:0] copy_sum;
	reg        in_flag_d;
	reg        exec_we_d;
	reg        t_we_d;
	reg        m_we_d;
	reg        n_we_d;
	reg        u_we_d;
	wire       take;
	wire       res_zero;
	wire [7:0] or_res;
	wire [7:0] xor_res;
	wire [7:0] and_res;

	assign file_val = file_mem[file_q];
	assign is_logic = (op_q == `LOA_OP_OR) | (op_q == `LOA_OP_XOR) |
		(op_q == `LOA_OP_AND);
	assign is_copy  = (op_q == `LOA_OP_COPY);
	assign inhibit  = r_q[`LOA_R_INHIBIT];
	assign dst      = r_q[2:0];
	assign take     = (state_q == ST_IDLE) & cmd_valid;
	assign res_zero = (res_d == `LOA_RST_BYTE);

	// Per-command results; the operate code picks one below
	assign or_res  = file_val | logic_opnd; // [RQ1]
	// Both operand bits give all ones, so this is the complement
	assign xor_res = file_val ^ logic_opnd; // [RQ2] [RQ10]
	// Both operand bits give all ones, so the file passes through
	assign and_res = file_val & logic_opnd; // [RQ3] [RQ11]

	// Operand for the logical commands
	loa_operand_sel u_opnd (
		.t_val    (t_q),
		.in_bus   (in_bus),
		.in_flag  (in_flag_q),
		.sel_true (c_q[`LOA_C_TRUE]),
		.sel_comp (c_q[`LOA_C_COMP]),
		.operand  (logic_opnd)
	); // [RQ6] [RQ7] [RQ9]

	// Copy source: transfer register or input bus, else zero
	assign copy_src = c_q[`LOA_C_TRUE] ? (in_flag_q ? in_bus : t_q) :
		`LOA_RST_BYTE; // [RQ16] [RQ18]

	// Result and write enables
	always @* begin
		res_d      = `LOA_RST_BYTE;
		file_we_d  = 1'b0;
		flags_we_d = 1'b0;
		copy_sum   = 9'h000;
		case (op_q)
			`LOA_OP_OR: begin
				res_d = or_res; // [RQ1]
			end
			`LOA_OP_XOR: begin
				res_d = xor_res; // [RQ2]
			end
			`LOA_OP_AND: begin
				res_d = and_res; // [RQ3]
			end
			`LOA_OP_COPY: begin
				copy_sum = {1'b0, copy_src} +
					{8'h00, c_q[`LOA_C_ADD1]} +
					{8'h00, c_q[`LOA_C_LINK] & link_q}; // [RQ19]
				res_d = copy_sum[7:0];
			end
			default: begin
				res_d = `LOA_RST_BYTE;
			end
		endcase
		if (is_logic) begin
			file_we_d = ~inhibit; // [RQ1] [RQ2] [RQ3] [RQ13] [RQ15]
		end
		if (is_copy) begin
			// File zero cannot be loaded by a copy
			file_we_d = ~inhibit & (file_q != 4'h0); // [RQ17]
		end
		flags_we_d = (is_logic | is_copy) & c_q[`LOA_C_FLAGS]; // [RQ8]
	end

	// Condition flag values
	always @* begin
		neg_d = res_d[7];
		if (c_q[`LOA_C_LINK] & is_logic) begin
			// Chained zero test: flag may clear but never set
			zero_d = zero_q & res_zero; // [RQ5]
		end else begin
			zero_d = res_zero;
		end
	end

	// Input select flag: only the set and clear commands move it
	always @* begin
		in_flag_d = in_flag_q;
		if (state_q == ST_EXEC) begin
			if (op_q == `LOA_OP_INSET) begin
				in_flag_d = 1'b1; // [RQ18]
			end
			if (op_q == `LOA_OP_INCLR) begin
				in_flag_d = 1'b0;
			end
		end
	end

	// Destination strobes: at most one register besides the file
	always @* begin
		exec_we_d = (state_q == ST_EXEC) & (is_logic | is_copy);
		t_we_d    = 1'b0;
		m_we_d    = 1'b0;
		n_we_d    = 1'b0;
		u_we_d    = 1'b0;
		case (dst)
			`LOA_DST_T: begin
				t_we_d = exec_we_d; // [RQ13] [RQ18]
			end
			`LOA_DST_M: begin
				m_we_d = exec_we_d;
			end
			`LOA_DST_N: begin
				n_we_d = exec_we_d; // [RQ14] [RQ16]
			end
			`LOA_DST_U: begin
				u_we_d = exec_we_d;
			end
			default: begin
				// No destination register: file (unless bit 3 inhibits it) and flags only
				t_we_d = 1'b0; // [RQ15]
			end
		endcase
	end

	// Sequencer: take, execute, report
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (cmd_valid) begin
					state_d = ST_EXEC;
				end
			end
			ST_EXEC: begin
				state_d = ST_DONE;
			end
			ST_DONE: begin
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_q     <= ST_IDLE;
			cmd_ready_q <= 1'b1;
			cmd_done_q  <= `LOA_RST_BIT;
		end else begin
			state_q    <= state_d;
			// Execution takes two cycles, well inside the period
			cmd_done_q <= (state_q == ST_EXEC); // [RQ12]
			if (take) begin
				cmd_ready_q <= 1'b0;
			end
			if (state_q == ST_DONE) begin
				cmd_ready_q <= 1'b1;
			end
		end
	end

	// Command latch: fields stay fixed until the next take
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			op_q   <= `LOA_OP_COPY;
			file_q <= `LOA_RST_NIB;
			c_q    <= `LOA_RST_NIB;
			r_q    <= `LOA_RST_NIB;
		end else if (take) begin
			op_q   <= cmd_op;
			file_q <= cmd_file;
			c_q    <= cmd_c;
			r_q    <= cmd_r;
		end
	end

	// Destination registers and result
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			result_q <= `LOA_RST_BYTE;
			t_q      <= `LOA_RST_BYTE;
			m_q      <= `LOA_RST_BYTE;
			n_q      <= `LOA_RST_BYTE;
			u_q      <= `LOA_RST_BYTE;
		end else begin
			if (t_load) begin
				t_q <= t_load_data;
			end
			if (exec_we_d) begin
				result_q <= res_d;
			end
			// Command write wins over an outside load
			if (t_we_d) begin
				t_q <= res_d; // [RQ13]
			end
			if (m_we_d) begin
				m_q <= res_d;
			end
			if (n_we_d) begin
				n_q <= res_d; // [RQ14]
			end
			if (u_we_d) begin
				u_q <= res_d;
			end
		end
	end

	// Condition flags move only while a command executes with bit 4 set
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			zero_q <= `LOA_RST_BIT;
			neg_q  <= `LOA_RST_BIT;
		end else if ((state_q == ST_EXEC) & flags_we_d) begin
			zero_q <= zero_d; // [RQ8]
			neg_q  <= neg_d;
		end
	end

	// Carry is loaded only from outside; these commands keep it
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			link_q <= `LOA_RST_BIT;
		end else if (link_load) begin
			link_q <= link_load_val; // [RQ4]
		end
	end

	// Input select flag register
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			in_flag_q <= `LOA_RST_BIT;
		end else begin
			in_flag_q <= in_flag_d; // [RQ18]
		end
	end

	// File register array with read port
	integer fi;
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			for (fi = 0; fi < `LOA_FILE_CNT; fi = fi + 1) begin
				file_mem[fi] <= `LOA_RST_BYTE;
			end
			file_rd_q <= `LOA_RST_BYTE;
		end else begin
			if (file_wr) begin
				file_mem[file_wr_addr] <= file_wr_data;
			end
			// Command write wins over an outside write to the same file
			if ((state_q == ST_EXEC) & file_we_d) begin
				file_mem[file_q] <= res_d; // [RQ1] [RQ14] [RQ16]
			end
			file_rd_q <= file_mem[file_rd_addr];
		end
	end

endmodule

//--- verification/loa_alu_assertions.sv
// Checker of the logical operate unit, bound to its top module.
// Assumes one clock and the asynchronous active-low reset.
`timescale 1ns/10ps
module loa_alu_chk (
	input wire       clk_sys,     // Clock
	input wire       arst_n,      // Reset
	input wire       cmd_valid,   // Request
	input wire [2:0] cmd_op,      // Op code
	input wire [3:0] cmd_c,       // Field
	input wire [3:0] cmd_r,       // Destination
	input wire       t_load,      // T load
	input wire       link_load,   // Link load
	input wire       cmd_ready_q, // Ready
	input wire       cmd_done_q,  // Done
	input wire [7:0] result_q,    // Result
	input wire [7:0] t_q,         // T
	input wire       zero_q,      // Zero
	input wire       neg_q,       // Negative
	input wire       link_q,      // Carry
	input wire       in_flag_q    // Input flag
);
	reg  [10:0] cmd_h;
	wire [2:0]  op_h = cmd_h[10:8];
	wire [3:0]  c_h  = cmd_h[7:4];
	wire        lg_h = op_h != 3'h0 && op_h < 3'h4;
	// Command held from the take edge on
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			cmd_h <= 11'h000;
		else if (cmd_valid && cmd_ready_q)
			cmd_h <= {cmd_op, cmd_c, cmd_r};
	end
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);
	sequence s_take;
		cmd_valid && cmd_ready_q;
	endsequence
	sequence s_answer;
		cmd_done_q ##1 !cmd_done_q && cmd_ready_q;
	endsequence
	property p_cycle; s_take |=> !cmd_ready_q ##1 s_answer; endproperty
	a_cycle: assert property (p_cycle) else $error("command timing");
	property p_link; !link_load |=> $stable(link_q); endproperty
	a_link: assert property (p_link) else $error("carry changed");
	property p_hold; cmd_done_q && !c_h[0] |-> $stable(zero_q) && $stable(neg_q); endproperty
	a_hold: assert property (p_hold) else $error("flags changed");
	property p_flags; cmd_done_q && c_h[0] && !c_h[3] && op_h < 3'h4
		|-> zero_q == (result_q == 8'h00) && neg_q == result_q[7]; endproperty
	a_flags: assert property (p_flags) else $error("flags wrong");
	property p_chain; cmd_done_q && c_h[0] && c_h[3] && lg_h
		|-> zero_q == ($past(zero_q) && result_q == 8'h00); endproperty
	a_chain: assert property (p_chain) else $error("chained zero");
	property p_dest_t; cmd_done_q && op_h < 3'h4 && cmd_h[2:0] == 3'h1 |-> t_q == result_q;
	endproperty
	a_dest_t: assert property (p_dest_t) else $error("T not written");
	property p_t_keep; cmd_done_q && cmd_h[2:0] != 3'h1 && !$past(t_load) |-> $stable(t_q);
	endproperty
	a_t_keep: assert property (p_t_keep) else $error("T altered");
	property p_input; cmd_done_q && op_h[2:1] == 2'b10 |-> in_flag_q == !op_h[0]; endproperty
	a_input: assert property (p_input) else $error("input flag");
endmodule
bind loa_alu loa_alu_chk loa_alu_chk_inst (.clk_sys, .arst_n, .cmd_valid, .cmd_op, .cmd_c,
	.cmd_r, .t_load, .link_load, .cmd_ready_q, .cmd_done_q, .result_q, .t_q, .zero_q,
	.neg_q, .link_q, .in_flag_q);

//--- verification/loa_seq_model.sv
// Sequencer model: holds one command until the unit takes it.
// Assumes the bench hands in requests between clock edges.
`timescale 1ns/10ps
module loa_seq_model (
	input  wire        clk_sys,     // Clock
	input  wire        arst_n,      // Reset
	input  wire        cmd_ready_q, // Unit ready
	input  wire        in_flag_q,   // Input flag
	input  wire        go,          // New request
	input  wire [14:0] cmd_in,      // Op, file, field, destination
	output reg         cmd_valid,   // Request held
	output wire [14:0] cmd_out      // Command to the unit
);
	reg [14:0] cmd_q;
	wire       drop_comp;
	// Complement bit of OR, XOR and AND dropped while input is selected
	assign drop_comp = in_flag_q & (cmd_q[14:12] != 3'h0) & (cmd_q[14:12] < 3'h4);
	assign cmd_out   = cmd_q & ~{8'h00, drop_comp, 6'h00};
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cmd_valid <= 1'b0;
			cmd_q     <= 15'h0000;
		end else if (cmd_valid && cmd_ready_q) begin
			// Released fields turn to the inverse
			cmd_valid <= 1'b0;
			cmd_q     <= ~cmd_q;
		end else if (go && !cmd_valid) begin
			cmd_valid <= 1'b1;
			cmd_q     <= cmd_in;
		end
	end
endmodule

//--- verification/tb.sv
// Self-checking bench of the logical operate unit.
// Assumes the sequencer model and the bound checker.
`timescale 1ns/10ps
`include "loa_consts.vh"
`define CHK(a, b) chk((a) === (b))
module tb;
	reg         clk_sys = 1'b0;
	reg         arst_n = 1'b0;
	reg         go = 1'b0;
	reg  [14:0] cmd_in = 15'h0000;
	reg  [7:0]  in_bus = 8'hC3;
	reg         t_load = 1'b0;
	reg  [7:0]  t_load_data = 8'h00;
	reg         link_load = 1'b0;
	reg         link_load_val = 1'b1;
	reg         file_wr = 1'b0;
	reg  [3:0]  file_wr_addr = 4'h0;
	reg  [7:0]  file_wr_data = 8'h00;
	reg  [3:0]  file_rd_addr = 4'h0;
	wire        cmd_valid, cmd_ready_q, cmd_done_q, zero_q, neg_q, link_q, in_flag_q;
	wire [2:0]  cmd_op;
	wire [3:0]  cmd_file, cmd_c, cmd_r;
	wire [7:0]  result_q, t_q, m_q, n_q, u_q, file_rd_q;
	int         errors = 0;
	int         num_checks = 0;
	int         cyc = 0;
	loa_seq_model loa_seq_model_inst (.clk_sys, .arst_n, .cmd_ready_q, .in_flag_q, .go,
		.cmd_in, .cmd_valid, .cmd_out({cmd_op, cmd_file, cmd_c, cmd_r}));
	loa_alu loa_alu_inst (.clk_sys, .arst_n, .cmd_valid, .cmd_op, .cmd_file, .cmd_c, .cmd_r,
		.in_bus, .t_load, .t_load_data, .link_load, .link_load_val, .file_wr,
		.file_wr_addr, .file_wr_data, .file_rd_addr, .cmd_ready_q, .cmd_done_q, .result_q,
		.t_q, .m_q, .n_q, .u_q, .zero_q, .neg_q, .link_q, .in_flag_q, .file_rd_q);
	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			errors = errors + 1;
			end_of_test;
		end
	end
	task end_of_test;
		begin
			$display("checks %0d errors %0d", num_checks, errors);
			if (errors == 0 && num_checks > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	task chk(input bit ok);
		begin
			num_checks = num_checks + 1;
			if (!ok) begin
				errors = errors + 1;
				$display("[FAIL] %0t value mismatch", $time);
			end
		end
	endtask
	// Word nibbles: op, file, field, destination
	task cmd(input [15:0] w);
		int n;
		begin
			@(negedge clk_sys);
			go = 1'b1;
			cmd_in = w[14:0];
			@(negedge clk_sys);
			go = 1'b0;
			n = 1;
			while (cmd_done_q !== 1'b1 && n < 20) begin
				@(negedge clk_sys);
				n = n + 1;
			end
			`CHK(n <= `LOA_EXEC_CYC, 1'b1);
		end
	endtask
	// Preload the addressed file and T, then issue the command
	task run(input [7:0] fv, input [7:0] tv, input [15:0] w);
		begin
			@(negedge clk_sys);
			file_wr = 1'b1;
			file_wr_addr = w[11:8];
			file_wr_data = fv;
			t_load = 1'b1;
			t_load_data = tv;
			@(negedge clk_sys);
			file_wr = 1'b0;
			t_load = 1'b0;
			cmd(w);
		end
	endtask
	task rd(input [3:0] f, input [7:0] v);
		begin
			@(negedge clk_sys);
			file_rd_addr = f;
			@(negedge clk_sys);
			`CHK(file_rd_q, v);
		end
	endtask
	initial begin
		repeat (16) @(posedge clk_sys);
		@(negedge clk_sys);
		arst_n = 1'b1;
		link_load = 1'b1;
		@(negedge clk_sys);
		link_load = 1'b0;
		run(8'h68, 8'h34, 16'h1120);
		`CHK(result_q, 8'h7C);
		rd(4'h1, 8'h7C);
		run(8'h6C, 8'h1A, 16'h2129);
		`CHK(t_q, 8'h76);
		rd(4'h1, 8'h6C);
		run(8'hA5, 8'h00, 16'h2163);
		`CHK(n_q, 8'h5A);
		rd(4'h1, 8'h5A);
		run(8'hA5, 8'h33, 16'h316B);
		`CHK(n_q, 8'hA5);
		run(8'h6B, 8'hAD, 16'h3120);
		rd(4'h1, 8'h29);
		run(8'hA5, 8'hD3, 16'h3140);
		rd(4'h1, 8'h24);
		run(8'h5C, 8'hFF, 16'h1103);
		`CHK(n_q, 8'h5C);
		rd(4'h1, 8'h5C);
		run(8'h00, 8'h00, 16'h3118);
		`CHK(zero_q, 1'b1);
		run(8'h01, 8'h02, 16'h11B8);
		`CHK({zero_q, t_q}, 9'h002);
		rd(4'h1, 8'h01);
		run(8'h00, 8'h00, 16'h3198);
		`CHK(zero_q, 1'b0);
		run(8'h80, 8'h00, 16'h1118);
		`CHK(neg_q, 1'b1);
		run(8'h00, 8'h00, 16'h1108);
		`CHK({zero_q, neg_q}, 2'b01);
		run(8'h99, 8'h34, 16'h0163);
		`CHK(n_q, 8'h35);
		rd(4'h1, 8'h35);
		run(8'h99, 8'h34, 16'h0103);
		`CHK(n_q, 8'h00);
		rd(4'h1, 8'h00);
		run(8'h05, 8'h00, 16'h0030);
		`CHK(zero_q, 1'b1);
		rd(4'h0, 8'h05);
		run(8'h0F, 8'hF0, 16'h1122);
		`CHK(m_q, 8'hFF);
		run(8'h3C, 8'h0F, 16'h212C);
		`CHK(u_q, 8'h33);
		run(8'h00, 8'h34, 16'h01A0);
		rd(4'h1, 8'h35);
		cmd(16'h4000);
		`CHK(in_flag_q, 1'b1);
		run(8'h11, 8'h22, 16'h0121);
		`CHK(t_q, 8'hC3);
		rd(4'h1, 8'hC3);
		run(8'h10, 8'h22, 16'h1120);
		rd(4'h1, 8'hD3);
		cmd(16'h5000);
		`CHK({in_flag_q, link_q}, 2'b01);
		end_of_test;
	end
endmodule
